// file: bench/smps_sva.sv
// checker for the link between the memory device end and the bus master end
`timescale 1ns/1ps
module smps_sva (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic pause_b,
  input wire logic so
);
  logic [7:0] op_r;
  logic [3:0] cnt_r;
  logic       slp_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // opcode shadow; arms sleep when cs rises after exactly eight bits of opcode B9
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_r  <= 8'h00;
      cnt_r <= 4'h0;
      slp_r <= 1'b0;
    end else begin
      if (cs_b) begin
        cnt_r <= 4'h0;
      end else if ($fell(sck) && pause_b && cnt_r != 4'hF) begin
        op_r  <= {op_r[6:0], si};
        cnt_r <= cnt_r + 4'h1;
      end
      if ($rose(cs_b) && cnt_r == 4'h8 && op_r == 8'hB9) begin
        slp_r <= 1'b1;
      end else if ($fell(cs_b)) begin
        slp_r <= 1'b0;
      end
    end
  end
  // device output and host framing relations
  a_so_off_cs_high: assert property (cs_b [*6] |-> !so_oe)
    else $error("so driven while deselected");
  a_so_off_paused: assert property ((!pause_b) [*6] |-> !so_oe)
    else $error("so driven while paused");
  a_pause_sck_low: assert property ($changed(pause_b) |-> !sck)
    else $error("pause moved with sck high");
  a_frame_sck_low: assert property ($fell(cs_b) |-> !sck)
    else $error("frame opened with sck high");
  a_sck_idle_low: assert property (cs_b && $past(cs_b) |-> !sck)
    else $error("sck runs outside a frame");
  a_si_stable_fall: assert property ($fell(sck) && !cs_b |-> $stable(si))
    else $error("si moved at its sampling edge");
  a_asleep_so_off: assert property (slp_r |-> !so_oe && so)
    else $error("so driven while asleep");
  a_wake_so_off: assert property ($fell(cs_b) && slp_r |-> (!so_oe) [*8])
    else $error("so driven during wake recovery");
  c_sleep: cover property ($rose(slp_r));
  c_pause: cover property ($fell(pause_b) && !cs_b);
  c_drive_zero: cover property (so_oe && !so_o);
endmodule : smps_sva

// file: bench/tb_top.sv
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ps
`include "smps_regs.svh"
module tb_top;
  localparam logic [15:0] PROD = `SMPS_PROD_CODE;
  logic        clk_i, rst_b_i, start_i, pause_i;
  logic        busy_o, byte_vld_o, crc_ok_o, asleep_o, awake_o;
  logic [7:0]  op_i, byte_o, c;
  logic [3:0]  nbytes_i;
  logic [7:0]  got [9];
  logic [7:0]  exp [9];
  logic [55:0] sn;
  int          nb, mismatches, check_count, k;
  smps_if lnk ();
  smps_dev u_smps_dev (.clk_i(clk_i), .rst_b_i(rst_b_i), .sck_i(lnk.sck), .lnk(lnk),
    .asleep_o(asleep_o), .awake_o(awake_o));
  smps_hst u_smps_hst (.clk_i(clk_i), .rst_b_i(rst_b_i), .lnk(lnk), .start_i(start_i),
    .op_i(op_i), .nbytes_i(nbytes_i), .pause_i(pause_i), .busy_o(busy_o),
    .byte_vld_o(byte_vld_o), .byte_o(byte_o), .crc_ok_o(crc_ok_o), .sck_o(), .cs_b_o(),
    .si_o(), .pause_b_o());
  smps_sva u_smps_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .sck(lnk.sck), .cs_b(lnk.cs_b),
    .si(lnk.si), .so_o(lnk.so_o), .so_oe(lnk.so_oe), .pause_b(lnk.pause_b), .so(lnk.so));
  // verdict and end of run
  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic fail(input string msg);
    mismatches++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask : fail
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) fail($sformatf("byte got %h exp %h", g, e));
  endtask : chk_byte
  task automatic chk_bit(input logic g, input logic e);
    check_count++;
    if (g !== e) fail($sformatf("flag got %b exp %b", g, e));
  endtask : chk_bit
  // a bounded wait that ran out ends the run
  task automatic hung(input int n);
    if (n >= 60) begin
      fail("wait ran out");
      report_and_stop();
    end
  endtask : hung
  // one frame: opcode, n bytes back, optional pause from cycle p for 60 cycles
  task automatic xfer(input logic [7:0] op, input logic [3:0] n, input int p);
    int t;
    nb = 0;
    @(posedge clk_i);
    #1 start_i = 1'b1;
    op_i = op;
    nbytes_i = n;
    @(posedge clk_i);
    #1 start_i = 1'b0;
    for (t = 0; t < 4000 && (busy_o !== 1'b0 || t < 2); t++) begin
      @(posedge clk_i);
      #1 if (t == p) pause_i = 1'b1;
      if (t == p + 60) pause_i = 1'b0;
      if (byte_vld_o === 1'b1 && nb < 9) got[nb++] = byte_o;
    end
    if (t == 4000) hung(60);
  endtask : xfer
  task automatic chk_frame(input int n);
    chk_byte(8'(nb), 8'(n));
    for (int i = 0; i < n; i++) chk_byte(got[i], exp[i]);
  endtask : chk_frame
  // bitwise crc-8, generator 07, zero start, no final inversion
  function automatic logic [7:0] crc_step(input logic [7:0] r0, input logic [7:0] d);
    logic [7:0] r;
    r = r0 ^ d;
    repeat (8) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction : crc_step
  // free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // main sequence
  initial begin
    {rst_b_i, start_i, pause_i, op_i, nbytes_i} = '0;
    {mismatches, check_count} = '0;
    repeat (10) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    chk_bit(awake_o, 1'b1);
    chk_bit(asleep_o, 1'b0);
    for (k = 0; k < 7; k++) exp[k] = (k < 6) ? `SMPS_MAKER_CONT : `SMPS_MAKER_CODE;
    exp[7] = PROD[15:8];
    exp[8] = PROD[7:0];
    xfer(`SMPS_OP_READ_IDENTITY_CMD, 4'h9, -100);
    chk_frame(9);
    xfer(`SMPS_OP_READ_IDENTITY_CMD, 4'h9, 200);
    chk_frame(9);
    // serial number: customer id, unique value, crc over the first seven
    sn = {`SMPS_CUST_ID, `SMPS_UNIQUE};
    c = 8'h00;
    for (k = 0; k < 7; k++) begin
      exp[k] = sn[55-8*k -: 8];
      c = crc_step(c, exp[k]);
    end
    exp[7] = c;
    xfer(`SMPS_OP_SERIAL, 4'h8, -100);
    chk_frame(8);
    chk_byte(got[0] | got[1], 8'h00);
    chk_bit(crc_ok_o, 1'b1);
    // sleep, dummy wake-up frame, then identity again
    xfer(`SMPS_OP_SLEEP, 4'h0, -100);
    for (k = 0; k < 60 && asleep_o !== 1'b1; k++) @(posedge clk_i);
    hung(k);
    chk_bit(asleep_o, 1'b1);
    chk_bit(awake_o, 1'b0);
    xfer(`SMPS_OP_READ, 4'h0, -100);
    for (k = 0; k < 60 && awake_o !== 1'b1; k++) @(posedge clk_i);
    hung(k);
    chk_bit(awake_o, 1'b1);
    for (k = 0; k < 7; k++) exp[k] = (k < 6) ? `SMPS_MAKER_CONT : `SMPS_MAKER_CODE;
    exp[7] = PROD[15:8];
    exp[8] = PROD[7:0];
    xfer(`SMPS_OP_READ_IDENTITY_CMD, 4'h9, -100);
    chk_frame(9);
    report_and_stop();
  end
endmodule : tb_top

// file: design/smps_dev.sv
// memory device end: pause, sleep, identity and serial number readout
`timescale 1ns/1ps
`include "smps_regs.svh"
module smps_dev import smps_pkg::*; (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic sck_i,
  smps_if.dev       lnk,
  output logic      asleep_o,
  output logic      awake_o
);
  // shift logic on link clock; power state on system clock
  localparam logic [71:0] ID_WORD = {{6{`SMPS_MAKER_CONT}}, `SMPS_MAKER_CODE,
                                     `SMPS_PROD_CODE};
  localparam int WAKE_CYC = `SMPS_WAKE_CYC;
  // 16k row count kept for endurance accounting; no array here
  localparam int ROWS = 16384;

  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 55; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ `SMPS_CRC_POLY : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8
  localparam logic [55:0] SER_HI = {`SMPS_CUST_ID, `SMPS_UNIQUE};
  localparam logic [63:0] SER_WORD = {SER_HI, crc8(SER_HI)};

  // link-domain state
  typedef struct packed {
    logic [7:0]  op;
    logic [6:0]  cnt;
    logic        out_en;
    logic [71:0] sh;
  } smps_lnk_t;
  smps_lnk_t l_r, l_nxt;
  logic held;          // pause pin level, active while low
  logic frame_rst_b;   // frame state cleared by reset or deselect
  logic sleep_tgl_r;   // flips once per accepted sleep request
  logic sleep_lnk;     // sleep level seen in link domain
  logic asleep_s1_r, asleep_s2_r;
  logic wake_b;

  // pause acts on its level: the master only moves it while sck is low,
  // so the next sck fall already sees the settled value and no edge is lost
  assign held = ~lnk.pause_b;
  // deselect clears the frame with constants only
  assign frame_rst_b = rst_b_i & ~lnk.cs_b;

  // asleep level into link domain
  always_ff @(posedge sck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      asleep_s1_r <= 1'b0;
      asleep_s2_r <= 1'b0;
    end else begin
      asleep_s1_r <= asleep_o;
      asleep_s2_r <= asleep_s1_r;
    end
  end
  assign sleep_lnk = asleep_s2_r | ~awake_o;

  // command decode and readout shift
  always_comb begin
    l_nxt = l_r;
    if (!held && !sleep_lnk) begin
      if (l_r.cnt != 7'd127) l_nxt.cnt = l_r.cnt + 7'd1;
      // one bit per fall once loaded; the loading fall shows bit 71
      if (l_r.out_en) l_nxt.sh = {l_r.sh[70:0], 1'b0};
      if (l_r.cnt < 7'd8) begin
        l_nxt.op = {l_r.op[6:0], lnk.si};
        if (l_r.cnt == 7'd7) begin
          case ({l_r.op[6:0], lnk.si})
            `SMPS_OP_READ_IDENTITY_CMD: begin
              l_nxt.sh = ID_WORD;
              l_nxt.out_en = 1'b1;
            end
            `SMPS_OP_SERIAL: begin
              l_nxt.sh = {SER_WORD, 8'h00};
              l_nxt.out_en = 1'b1;
            end
            default: l_nxt.out_en = 1'b0;
          endcase
        end
      end
    end
  end

  // sck falling edge advances the frame; cs high restarts it
  always_ff @(negedge sck_i or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // cs rise after exactly eight sleep bits flips the request toggle;
  // it reads the frame state before the deselect clear lands
  always_ff @(posedge lnk.cs_b or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sleep_tgl_r <= 1'b0;
    end else if (l_r.op == `SMPS_OP_SLEEP && l_r.cnt == 7'd8 && !sleep_lnk) begin
      sleep_tgl_r <= ~sleep_tgl_r;
    end
  end

  // output msb first, released on pause, sleep or deselect
  assign lnk.so_o = l_r.sh[71];
  assign lnk.so_oe = l_r.out_en & ~lnk.cs_b & ~held & ~sleep_lnk;

  // system-domain power state
  typedef struct packed {
    smps_pwr_t  pwr;
    logic [3:0] tgl_s;
    logic [3:0] wake_cnt;
    logic       asleep;
    logic       awake;
  } smps_sys_t;
  smps_sys_t s_r, s_nxt;

  smps_sync u_cs_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (lnk.cs_b),
    .q_o     (wake_b)
  );

  // toggle from link marks sleep request; cs fall starts recovery
  always_comb begin
    s_nxt = s_r;
    s_nxt.tgl_s = {s_r.tgl_s[2:0], sleep_tgl_r};
    case (s_r.pwr)
      SMPS_AWAKE: begin
        if (s_r.tgl_s[2] != s_r.tgl_s[3]) s_nxt.pwr = SMPS_ASLEEP;
      end
      SMPS_ASLEEP: begin
        if (!wake_b) begin
          s_nxt.pwr = SMPS_WAKING;
          // the cs synchroniser and the state steps already spent six cycles of the recovery time
          s_nxt.wake_cnt = 4'(WAKE_CYC - 6);
        end
      end
      SMPS_WAKING: begin
        if (s_r.wake_cnt == 4'h0) s_nxt.pwr = SMPS_AWAKE;
        else s_nxt.wake_cnt = s_r.wake_cnt - 4'h1;
      end
      default: s_nxt.pwr = SMPS_AWAKE;
    endcase
    s_nxt.asleep = (s_nxt.pwr == SMPS_ASLEEP);
    s_nxt.awake = (s_nxt.pwr == SMPS_AWAKE);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) s_r <= '{pwr: SMPS_AWAKE, tgl_s: 4'h0, wake_cnt: 4'h0,
                           asleep: 1'b0, awake: 1'b1};
    else s_r <= s_nxt;
  end
  assign asleep_o = s_r.asleep;
  assign awake_o = s_r.awake;
endmodule : smps_dev

// file: design/smps_hst.sv
// bus master end: sends one opcode and reads back bytes
`timescale 1ns/1ps
`include "smps_regs.svh"
module smps_hst import smps_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  smps_if.hst             lnk,
  input  wire logic       start_i,
  input  wire logic [7:0] op_i,
  input  wire logic [3:0] nbytes_i,
  input  wire logic       pause_i,
  output logic            busy_o,
  output logic            byte_vld_o,
  output logic [7:0]      byte_o,
  output logic            crc_ok_o,
  output logic            sck_o,
  output logic            cs_b_o,
  output logic            si_o,
  output logic            pause_b_o
);
  typedef struct packed {
    smps_hst_t  st;
    logic [1:0] div;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] bit_n;
    logic [3:0] left;
    logic       cmd;
    logic [7:0] crc;
    logic       sck;
    logic       cs_b;
    logic       pause_b;
    logic       vld;
    logic [7:0] dout;
    logic       ok;
  } smps_h_t;
  smps_h_t h_r, h_nxt;
  logic so_s;
  logic [7:0] rx_byte; // byte including the bit taken at this fall
  assign rx_byte = {h_r.rx[6:0], so_s};

  smps_sync u_so_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (lnk.so),
    .q_o     (so_s)
  );

  // divider makes sck; pause only moves while sck low
  always_comb begin
    h_nxt = h_r;
    h_nxt.vld = 1'b0;
    case (h_r.st)
      SMPS_H_IDLE: begin
        h_nxt.sck = 1'b0;
        h_nxt.cs_b = 1'b1;
        if (start_i) begin
          h_nxt.st = SMPS_H_SHIFT;
          h_nxt.cs_b = 1'b0;
          h_nxt.tx = op_i;
          h_nxt.bit_n = 3'd0;
          h_nxt.left = nbytes_i;
          h_nxt.cmd = 1'b1;
          h_nxt.crc = 8'h00;
          h_nxt.div = 2'd0;
        end
      end
      SMPS_H_SHIFT: begin
        h_nxt.div = h_r.div + 2'd1;
        if (h_r.div == 2'(`SMPS_SCK_DIV - 1) && h_r.pause_b) begin
          h_nxt.div = 2'd0;
          h_nxt.sck = ~h_r.sck;
          if (!h_r.sck) begin
            // si moves on the rise, half a period clear of the device's fall
            if (h_r.bit_n != 3'd0) h_nxt.tx = {h_r.tx[6:0], 1'b0};
          end else begin
            // synced so lags four cycles, so the bit shown at the last fall is taken
            h_nxt.rx = rx_byte;
            h_nxt.bit_n = h_r.bit_n + 3'd1;
            if (h_r.bit_n == 3'd7) begin
              if (h_r.cmd) h_nxt.cmd = 1'b0;
              else begin
                h_nxt.vld = 1'b1;
                h_nxt.dout = rx_byte;
                h_nxt.left = h_r.left - 4'd1;
                h_nxt.ok = (h_r.crc == rx_byte);
                h_nxt.crc = crc_byte(h_r.crc, rx_byte);
              end
              if ((h_r.cmd && h_r.left == 4'd0) || (!h_r.cmd && h_r.left == 4'd1))
                h_nxt.st = SMPS_H_GAP;
            end
          end
        end
      end
      SMPS_H_GAP: begin
        h_nxt.cs_b = 1'b1;
        h_nxt.st = SMPS_H_IDLE;
      end
      default: h_nxt.st = SMPS_H_IDLE;
    endcase
    // pause moves only where sck is low now and stays low next cycle
    if (!h_r.sck && !h_nxt.sck) h_nxt.pause_b = ~pause_i;
  end

  function automatic logic [7:0] crc_byte(input logic [7:0] c0, input logic [7:0] d);
    logic [7:0] c;
    c = c0 ^ d;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ `SMPS_CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction : crc_byte

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      h_r <= '0;
      h_r.cs_b <= 1'b1;
      h_r.pause_b <= 1'b1;
    end else h_r <= h_nxt;
  end

  assign lnk.sck = h_r.sck;
  assign lnk.cs_b = h_r.cs_b;
  assign lnk.si = h_r.tx[7];
  assign lnk.pause_b = h_r.pause_b;
  assign busy_o = (h_r.st != SMPS_H_IDLE);
  assign byte_vld_o = h_r.vld;
  assign byte_o = h_r.dout;
  assign crc_ok_o = h_r.ok;
  assign sck_o = h_r.sck;
  assign cs_b_o = h_r.cs_b;
  assign si_o = h_r.tx[7];
  assign pause_b_o = h_r.pause_b;
endmodule : smps_hst

// file: design/smps_if.sv
// link wires between memory device end and bus master end
`timescale 1ns/1ps
interface smps_if;
  logic sck;
  logic cs_b;
  logic si;
  logic so_o;
  logic so_oe;
  logic pause_b;
  logic so;
  assign so = so_oe ? so_o : 1'b1;
  modport dev (input sck, input cs_b, input si, input pause_b, output so_o, output so_oe);
  modport hst (output sck, output cs_b, output si, output pause_b, input so);
endinterface : smps_if

// file: design/smps_pkg.sv
// types shared by both ends of the serial memory link
package smps_pkg;
  typedef enum logic [1:0] {
    SMPS_AWAKE = 2'b00,
    SMPS_ASLEEP = 2'b01,
    SMPS_WAKING = 2'b10
  } smps_pwr_t;
  typedef enum logic [1:0] {
    SMPS_H_IDLE = 2'b00,
    SMPS_H_SHIFT = 2'b01,
    SMPS_H_GAP = 2'b10
  } smps_hst_t;
endpackage : smps_pkg

// file: design/smps_regs.svh
// constants for the serial memory pause, sleep and identity logic
`ifndef SMPS_REGS_SVH
`define SMPS_REGS_SVH
`define SMPS_OP_SLEEP      8'hB9
`define SMPS_OP_READ_IDENTITY_CMD       8'h9F
`define SMPS_OP_SERIAL     8'hC3
`define SMPS_OP_READ       8'h03
`define SMPS_MAKER_CONT    8'h5A
`define SMPS_MAKER_CODE    8'hA5
`define SMPS_PROD_CODE     16'h2400
`define SMPS_CUST_ID       16'h0000
`define SMPS_UNIQUE        40'h12_3456_789A
`define SMPS_CRC_POLY      8'h07
`define SMPS_WAKE_REC_NS   400
`define SMPS_CLK_NS        40
`define SMPS_WAKE_CYC      ((`SMPS_WAKE_REC_NS + `SMPS_CLK_NS - 1) / `SMPS_CLK_NS)
`define SMPS_SCK_DIV       4
`endif

// file: design/smps_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module smps_sync (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic [2:0] s_r;
  // stage chain; output moves when stages two and three agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= 3'b111;
      q_o <= 1'b1;
    end else begin
      s_r <= {s_r[1:0], d_i};
      if (s_r[1] == s_r[2]) q_o <= s_r[2];
    end
  end
endmodule : smps_sync
